// ### dpcr_pkg.sv
// Shared constants and carriers for the digital I/O port configuration block
// Assumes one host clock domain; pin levels arrive already synchronous
package dpcr_pkg;
  // ----------------------------------------
  // Port organisation
  // ----------------------------------------
  localparam int DPCR_GROUPS = 2;
  localparam int PORT_W = 8;
  localparam int NIB_W = 4;
  localparam int GRP_W = 3 * PORT_W;
  localparam int DIO_W = DPCR_GROUPS * GRP_W;
  localparam logic [PORT_W-1:0] PORT_ONES = 8'hff;
  localparam logic [PORT_W-1:0] PORT_ZEROS = 8'h00;
  localparam logic [NIB_W-1:0] NIB_ONES = 4'hf;
  localparam logic [NIB_W-1:0] NIB_ZEROS = 4'h0;
  // ----------------------------------------
  // Direction control word bits, 1 = input
  // ----------------------------------------
  localparam int CW_FIRST_BIT = 4;
  localparam int CW_THI_BIT = 3;
  localparam int CW_SECOND_BIT = 1;
  localparam int CW_TLO_BIT = 0;
  // Output data write strobes within a group
  localparam int OUT_FIRST = 2;
  localparam int OUT_SECOND = 1;
  localparam int OUT_THIRD = 0;
  // ----------------------------------------
  // Counters and interrupt sources
  // ----------------------------------------
  localparam int CNT_NUM = 3;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam int TMR_A = 0;
  localparam int TMR_B = 1;
  localparam int EVT_C = 2;
  localparam int THIRD_BIT0 = 0;
  localparam int THIRD_BIT4 = 4;
  localparam int IRQ_W = 6;
  localparam int IRQ_TMR_B = 4;
  localparam int IRQ_EVT_C = 5;
  localparam logic [IRQ_W-1:0] IRQ_NONE = 6'h00;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic first;
    logic second;
    logic third_lo;
    logic third_hi;
  } dpcr_unit_s;
  typedef struct packed {
    logic [PORT_W-1:0] first;
    logic [PORT_W-1:0] second;
    logic [PORT_W-1:0] third;
  } dpcr_port_s;
  typedef enum logic {
    DPCR_INIT = 1'b0,
    DPCR_RUN = 1'b1
  } dpcr_st_e;
endpackage

// ### dpcr_group.sv
// One group of three ports: direction, output values and warm-reset retention
// Assumes por_n falls only at power loss, rst_n on every host reset
`timescale 1ns/100ps
module dpcr_group
  import dpcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic retain_en,
  input wire dpcr_unit_s strap,
  input wire logic cw_wr,
  input wire logic [PORT_W-1:0] cw_data,
  input wire logic [2:0] out_wr,
  input wire logic [PORT_W-1:0] out_data,
  output dpcr_port_s pin_out,
  output dpcr_port_s pin_oe,
  output logic ready
);
  dpcr_st_e st_reg, st_next;
  dpcr_unit_s dir_reg, dir_next, ret_dir_reg, ret_dir_next;
  dpcr_port_s out_reg, out_next, oe_reg, oe_next, ret_out_reg, ret_out_next;
  logic ret_valid_reg, ret_valid_next;

  // ----------------------------------------
  // Live port state
  // ----------------------------------------
  // Next direction and output values
  always_comb begin
    st_next = st_reg;
    dir_next = dir_reg;
    out_next = out_reg;
    case (st_reg)
      DPCR_INIT: begin
        st_next = DPCR_RUN;
        if (retain_en && ret_valid_reg) begin
          dir_next = ret_dir_reg;
          out_next = ret_out_reg;
        end else begin
          // no retention, every reset gives defaults
          // software ports come up input high
          dir_next = ~strap;
          // forced ports come up driving low
          out_next.first = strap.first ? PORT_ZEROS : PORT_ONES;
          out_next.second = strap.second ? PORT_ZEROS : PORT_ONES;
          out_next.third = {strap.third_hi ? NIB_ZEROS : NIB_ONES,
                            strap.third_lo ? NIB_ZEROS : NIB_ONES};
        end
      end
      DPCR_RUN: begin
        if (cw_wr) begin
          dir_next.first = cw_data[CW_FIRST_BIT];
          dir_next.second = cw_data[CW_SECOND_BIT];
          dir_next.third_lo = cw_data[CW_TLO_BIT];
          dir_next.third_hi = cw_data[CW_THI_BIT];
        end
        if (out_wr[OUT_FIRST]) out_next.first = out_data;
        if (out_wr[OUT_SECOND]) out_next.second = out_data;
        if (out_wr[OUT_THIRD]) out_next.third = out_data;
      end
      default: st_next = DPCR_INIT;
    endcase
    dir_next = dir_next & ~strap;
    // nibbles of the third port steer separately
    oe_next.first = {PORT_W{~dir_next.first}};
    oe_next.second = {PORT_W{~dir_next.second}};
    oe_next.third = {{NIB_W{~dir_next.third_hi}}, {NIB_W{~dir_next.third_lo}}};
  end

  // Live registers, cleared by every host reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= DPCR_INIT;
      dir_reg <= '1;
      out_reg <= '1;
      oe_reg <= '0;
    end else begin
      st_reg <= st_next;
      dir_reg <= dir_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------
  // Retained copy
  // ----------------------------------------
  // every port recorded, forced or not
  always_comb begin
    ret_dir_next = ret_dir_reg;
    ret_out_next = ret_out_reg;
    ret_valid_next = ret_valid_reg;
    if (st_reg == DPCR_RUN) begin
      ret_dir_next = dir_reg;
      ret_out_next = out_reg;
      ret_valid_next = 1'b1;
    end
  end

  // only power-on reset touches this storage
  // power loss drops the retained copy
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      ret_dir_reg <= '1;
      ret_out_reg <= '1;
      ret_valid_reg <= 1'b0;
    end else begin
      ret_dir_reg <= ret_dir_next;
      ret_out_reg <= ret_out_next;
      ret_valid_reg <= ret_valid_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign ready = (st_reg == DPCR_RUN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_restore_values: assert property (
    (st_reg == DPCR_INIT) && retain_en && ret_valid_reg
    |=> (out_reg == $past(ret_out_reg)) && (dir_reg == ($past(ret_dir_reg) & ~strap)))
    else $error("retained state not restored");
  chk_por_defaults: assert property (
    (st_reg == DPCR_INIT) && !ret_valid_reg
    |=> (dir_reg == ~strap) && (oe_reg.first == {PORT_W{strap.first}}))
    else $error("power-on defaults wrong");
  chk_retain_forced_too: assert property (
    (st_reg == DPCR_RUN) |=> ret_valid_reg && (ret_out_reg == $past(out_reg)))
    else $error("retained copy lags live state");
  cov_warm_restore: cover property ((st_reg == DPCR_INIT) && retain_en && ret_valid_reg);
endmodule

// ### dpcr_top.sv
// Digital I/O port configuration with retention, counters and interrupt sources
// Assumes straps are static; ext clocks and pins are synchronous to clock
//
// Overview of operation
// - Forty-eight lines as six 8-bit ports in two groups of three.
// - Third port of each group has separate low and high nibble direction.
// - Software ports start as inputs reading high unless state is restored.
// - Forced-output ports ignore software attempts to make them inputs.
// - Forced-output ports start driving low unless state is restored.
// - With retention, direction and outputs are restored after a warm reset.
// - Retention covers software ports and forced-output ports alike.
// - Power loss clears retained state, so power-on gives the defaults.
// - Without retention every reset returns all ports to defaults.
// - Each counter picks external clock or internal source by strap.
// - Second timer internal source is first timer output, forming a cascade.
// - Interrupts come from third-port bits 0 and 4, timer two, counter three.
// - Third counter is a 16-bit event counter raising an event interrupt.
// - Interrupt output pin rises together with the host interrupt.
// - Interrupt pin is high while pending and low once cleared.
// - Control word D4 first, D3 third high, D1 second, D0 third low.
// - Control word has no effect on strap-forced output ports.
`timescale 1ns/100ps
module dpcr_top
  import dpcr_pkg::*;
#(
  parameter int INT_CLK_DIV = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic retain_state_strap,
  input wire logic grp0_first_port_dir_strap,
  input wire logic grp0_second_port_dir_strap,
  input wire logic grp0_third_low_nibble_strap,
  input wire logic grp0_third_high_nibble_strap,
  input wire logic grp1_first_port_dir_strap,
  input wire logic grp1_second_port_dir_strap,
  input wire logic grp1_third_low_nibble_strap,
  input wire logic grp1_third_high_nibble_strap,
  input wire logic timer_a_clock_select,
  input wire logic timer_b_clock_select,
  input wire logic event_counter_clock_select,
  input wire logic [DPCR_GROUPS-1:0] cw_wr,
  input wire logic [PORT_W-1:0] cw_data,
  input wire logic [3*DPCR_GROUPS-1:0] out_wr,
  input wire logic [PORT_W-1:0] out_data,
  input wire logic [DIO_W-1:0] pin_in,
  output logic [DIO_W-1:0] pin_out,
  output logic [DIO_W-1:0] pin_oe,
  output logic [DIO_W-1:0] port_read,
  input wire logic [CNT_NUM-1:0] ext_clk,
  input wire logic [CNT_NUM-1:0][CNT_W-1:0] cnt_reload,
  output logic [CNT_NUM-1:0] cnt_out,
  input wire logic [IRQ_W-1:0] irq_enable,
  input wire logic [IRQ_W-1:0] irq_clear,
  output logic [IRQ_W-1:0] irq_status,
  output logic host_irq,
  output logic int_out
);
  localparam int DIV_W = $clog2(INT_CLK_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_CLK_DIV - 1);

  dpcr_unit_s strap_g [DPCR_GROUPS];
  dpcr_port_s g_out [DPCR_GROUPS];
  dpcr_port_s g_oe [DPCR_GROUPS];
  logic [DPCR_GROUPS-1:0] g_ready;
  logic [DIO_W-1:0] read_reg, read_next;
  logic [CNT_NUM-1:0] sel_int, tick, term_next, term_reg, ext_prev_reg;
  logic [CNT_W-1:0] cnt_reg [CNT_NUM];
  logic [CNT_W-1:0] cnt_next [CNT_NUM];
  logic [DIV_W-1:0] div_reg, div_next;
  logic div_tick;
  logic [3:0] irq_line, line_prev_reg;
  logic [IRQ_W-1:0] irq_ev, stat_reg, stat_next;
  logic irq_reg, irq_next;
  logic grp0_third_bit0_irq_line, grp0_third_bit4_irq_line;
  logic grp1_third_bit0_irq_line, grp1_third_bit4_irq_line;

  // ----------------------------------------
  // Port groups
  // ----------------------------------------
  // Strap sets per group, 1 = forced output
  assign strap_g[0] = '{grp0_first_port_dir_strap, grp0_second_port_dir_strap,
                        grp0_third_low_nibble_strap, grp0_third_high_nibble_strap};
  assign strap_g[1] = '{grp1_first_port_dir_strap, grp1_second_port_dir_strap,
                        grp1_third_low_nibble_strap, grp1_third_high_nibble_strap};

  // two identical groups of three ports
  for (genvar g = 0; g < DPCR_GROUPS; g++) begin : gen_grp
    dpcr_group u_grp (
      .clock(clock),
      .rst_n(rst_n),
      .por_n(por_n),
      .retain_en(retain_state_strap),
      .strap(strap_g[g]),
      .cw_wr(cw_wr[g]),
      .cw_data(cw_data),
      .out_wr(out_wr[3*g +: 3]),
      .out_data(out_data),
      .pin_out(g_out[g]),
      .pin_oe(g_oe[g]),
      .ready(g_ready[g])
    );
    assign pin_out[GRP_W*g +: GRP_W] = g_out[g];
    assign pin_oe[GRP_W*g +: GRP_W] = g_oe[g];
  end

  // Readback: driven value on outputs, pin level on inputs
  always_comb begin
    read_next = (pin_oe & pin_out) | (~pin_oe & pin_in);
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  assign sel_int = {event_counter_clock_select, timer_b_clock_select,
                    timer_a_clock_select};
  assign div_tick = (div_reg == DIV_LAST);

  // Tick selection, count and terminal pulse
  always_comb begin
    div_next = div_tick ? '0 : div_reg + 1'b1;
    for (int i = 0; i < CNT_NUM; i++) begin
      tick[i] = sel_int[i] ? div_tick : (ext_clk[i] & ~ext_prev_reg[i]);
      cnt_next[i] = cnt_reg[i];
    end
    // timer two counts timer one terminals
    if (sel_int[TMR_B]) tick[TMR_B] = term_reg[TMR_A];
    for (int i = 0; i < CNT_NUM; i++) begin
      term_next[i] = tick[i] && (cnt_reg[i] == CNT_ZERO);
      if (tick[i]) cnt_next[i] = term_next[i] ? cnt_reload[i] : cnt_reg[i] - CNT_ONE;
    end
  end

  // Counter registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      ext_prev_reg <= '0;
      term_reg <= '0;
      for (int i = 0; i < CNT_NUM; i++) cnt_reg[i] <= CNT_ZERO;
    end else begin
      div_reg <= div_next;
      ext_prev_reg <= ext_clk;
      term_reg <= term_next;
      for (int i = 0; i < CNT_NUM; i++) cnt_reg[i] <= cnt_next[i];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign grp0_third_bit0_irq_line = read_reg[THIRD_BIT0];
  assign grp0_third_bit4_irq_line = read_reg[THIRD_BIT4];
  assign grp1_third_bit0_irq_line = read_reg[GRP_W + THIRD_BIT0];
  assign grp1_third_bit4_irq_line = read_reg[GRP_W + THIRD_BIT4];
  assign irq_line = {grp1_third_bit4_irq_line, grp1_third_bit0_irq_line,
                     grp0_third_bit4_irq_line, grp0_third_bit0_irq_line};

  // Sticky status, event wins over clear
  always_comb begin
    // event counter terminal raises its flag
    irq_ev = {term_reg[EVT_C], term_reg[TMR_B], irq_line & ~line_prev_reg} & irq_enable;
    stat_next = (stat_reg & ~irq_clear) | irq_ev;
    irq_next = |stat_next;
  end

  // pin and host request from one flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Idle high like pulled-up inputs, so release makes no false edge
      read_reg <= '1;
      line_prev_reg <= '1;
      stat_reg <= IRQ_NONE;
      irq_reg <= 1'b0;
    end else begin
      read_reg <= read_next;
      line_prev_reg <= irq_line;
      stat_reg <= stat_next;
      irq_reg <= irq_next;
    end
  end

  assign port_read = read_reg;
  assign cnt_out = term_reg;
  assign irq_status = stat_reg;
  assign host_irq = irq_reg;
  assign int_out = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_cw_dir_apply: assert property (
    g_ready[1] && cw_wr[1] && !strap_g[1].first && !strap_g[1].second
    |=> (g_oe[1].first == {PORT_W{~$past(cw_data[CW_FIRST_BIT])}})
        && (g_oe[1].second == {PORT_W{~$past(cw_data[CW_SECOND_BIT])}}))
    else $error("control word bits misapplied");
  chk_forced_oe: assert property (
    g_ready[1] && strap_g[1].third_hi |-> g_oe[1].third[PORT_W-1 -: NIB_W] == NIB_ONES)
    else $error("forced nibble released");
  chk_sw_default: assert property (
    $rose(g_ready[1]) && !retain_state_strap && !strap_g[1].first
    ##1 1'b1 |-> g_oe[1].first == PORT_ZEROS && g_out[1].first == PORT_ONES)
    else $error("software port not input high");
  chk_forced_low: assert property (
    $rose(g_ready[0]) && !retain_state_strap && strap_g[0].first
    ##1 1'b1 |-> g_oe[0].first == PORT_ONES && g_out[0].first == PORT_ZEROS)
    else $error("forced port not driving low");
  chk_irq_pin_sync: assert property (
    $rose(irq_status != IRQ_NONE) |-> $rose(host_irq) && $rose(int_out))
    else $error("interrupt pin not simultaneous");
  chk_irq_clear: assert property (
    int_out && ((irq_status & ~irq_clear) == IRQ_NONE) && (irq_ev == IRQ_NONE) |=> !int_out)
    else $error("interrupt pin stays high after clear");
  chk_cascade: assert property (
    sel_int[TMR_B] && term_reg[TMR_A] && cnt_reg[TMR_B] == CNT_ZERO |=> term_reg[TMR_B])
    else $error("timer cascade broken");
  chk_evt_irq: assert property (
    term_reg[EVT_C] && irq_enable[IRQ_EVT_C] |=> irq_status[IRQ_EVT_C] ##1 int_out)
    else $error("event interrupt missing");

  cov_cw_write: cover property (g_ready[0] && cw_wr[0]);
  cov_cascade: cover property (sel_int[TMR_B] && term_reg[TMR_B]);
  cov_irq_cycle: cover property ($rose(int_out) ##[1:20] $fell(int_out));
endmodule

// ### dpcr_field_model.sv
// Field device model for the 48 digital I/O lines of the port block
// Assumes pin_oe is high where the block drives; other lines have pull-ups
`timescale 1ns/100ps
module dpcr_field_model
  import dpcr_pkg::*;
(
  input wire logic [DIO_W-1:0] pin_out,
  input wire logic [DIO_W-1:0] pin_oe,
  input wire logic [DIO_W-1:0] ext_en,
  input wire logic [DIO_W-1:0] ext_val,
  output logic [DIO_W-1:0] pin_in
);
  // ----------------------------------------
  // Line levels
  // ----------------------------------------
  // Driven lines follow the block, then an external source, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// ### testbench.sv
// Self-checking bench for direction, retention, interrupt and counter behaviour
// Assumes the field model on the pins and a shortened internal tick divider
`timescale 1ns/100ps
module testbench
  import dpcr_pkg::*;
;
  logic clock, rst_n, por_n, ret, host_irq, int_out;
  logic [3:0] s [2];
  logic [3:0] din [2];
  logic [DIO_W-1:0] outv, ext_en, ext_val, pin_in, pin_out, pin_oe, port_read;
  logic [1:0] cw_wr;
  logic [7:0] cw_data, out_data;
  logic [5:0] out_wr, irq_enable, irq_clear, irq_status;
  logic [2:0] ext_clk, cnt_out, csel;
  logic [2:0][15:0] cnt_reload;
  int n_errors, tests_run, n_evt;
  int bl [4] = '{4, 3, 1, 0};
  localparam logic [47:0] VALS = 48'h5ac3_963c_69f0;
  // ----------------------------------------
  // Design and field side
  // ----------------------------------------
  dpcr_top #(.INT_CLK_DIV(2)) dut (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .retain_state_strap(ret),
    .grp0_first_port_dir_strap(s[0][3]), .grp0_second_port_dir_strap(s[0][2]),
    .grp0_third_low_nibble_strap(s[0][1]), .grp0_third_high_nibble_strap(s[0][0]),
    .grp1_first_port_dir_strap(s[1][3]), .grp1_second_port_dir_strap(s[1][2]),
    .grp1_third_low_nibble_strap(s[1][1]), .grp1_third_high_nibble_strap(s[1][0]),
    .timer_a_clock_select(csel[0]), .timer_b_clock_select(csel[1]),
    .event_counter_clock_select(csel[2]), .cw_wr(cw_wr), .cw_data(cw_data),
    .out_wr(out_wr), .out_data(out_data), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .port_read(port_read), .ext_clk(ext_clk), .cnt_reload(cnt_reload),
    .cnt_out(cnt_out), .irq_enable(irq_enable), .irq_clear(irq_clear),
    .irq_status(irq_status), .host_irq(host_irq), .int_out(int_out));
  dpcr_field_model field (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  // Clock generation
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Event counter terminal pulses, sampled mid-cycle
  always @(negedge clock) begin
    if (cnt_out[2] === 1'b1) n_evt++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected drive mask from straps and software direction
  function automatic logic [47:0] e_oe();
    logic [47:0] r;
    logic [3:0] o;
    for (int g = 0; g < 2; g++) begin
      o = s[g] | ~din[g];
      r[24*g+:24] = {{8{o[3]}}, {8{o[2]}}, {4{o[0]}}, {4{o[1]}}};
    end
    return r;
  endfunction
  task automatic check_state();
    logic [47:0] oe;
    oe = e_oe();
    cmp(pin_oe, oe);
    cmp(pin_out & oe, outv & oe);
    cmp(port_read, (oe & outv) | (~oe & ((ext_en & ext_val) | ~ext_en)));
  endtask
  task automatic wr_cw(input int g, input logic [7:0] d);
    @(posedge clock);
    cw_wr[g] <= 1'b1;
    cw_data <= d;
    @(posedge clock);
    cw_wr <= 2'b00;
    din[g] = {d[4], d[1], d[0], d[3]};
    tick(2);
  endtask
  task automatic wr_out(input int i, input logic [7:0] d);
    @(posedge clock);
    out_wr[i] <= 1'b1;
    out_data <= d;
    @(posedge clock);
    out_wr <= 6'h00;
    outv[8*i+:8] = d;
    tick(2);
  endtask
  // Mixed direction state with known output values
  task automatic set_mixed();
    for (int i = 0; i < 6; i++) wr_out(i, VALS[8*i+:8]);
    wr_cw(0, 8'h12);
    wr_cw(1, 8'h09);
  endtask
  task automatic do_reset(input logic p);
    @(posedge clock);
    rst_n <= 1'b0;
    por_n <= ~p;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    tick(3);
    if (p || !ret) begin
      din[0] = 4'hf;
      din[1] = 4'hf;
      outv = '0;
    end
  endtask
  task automatic wait_flag(input int i, input int lim);
    int n;
    n = 0;
    while (irq_status[i] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    cmp(48'(irq_status[i]), 48'h1);
    if (irq_status[i] !== 1'b1) complete_run();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    ret = 1'b1;
    s[0] = 4'b1000;
    s[1] = 4'b0001;
    cw_wr = 2'b00;
    cw_data = 8'h00;
    out_wr = 6'h00;
    out_data = 8'h00;
    ext_en = '0;
    ext_val = '0;
    ext_clk = 3'b000;
    csel = 3'b001;
    cnt_reload = {16'h0003, 16'h0002, 16'h0003};
    irq_enable = 6'h3f;
    irq_clear = 6'h00;
    outv = '0;
    n_errors = 0;
    tests_run = 0;
    n_evt = 0;
    do_reset(1'b1);
    check_state();
    for (int i = 0; i < 6; i++) wr_out(i, VALS[8*i+:8]);
    wr_cw(0, 8'h00);
    wr_cw(1, 8'h00);
    check_state();
    for (int k = 0; k < 4; k++) begin
      wr_cw(0, 8'h1b & ~(8'h01 << bl[k]));
      wr_cw(1, 8'h1b & ~(8'h01 << bl[k]));
      check_state();
    end
    wr_cw(0, 8'hff);
    wr_cw(1, 8'he4);
    check_state();
    set_mixed();
    check_state();
    do_reset(1'b0);
    check_state();
    @(posedge clock);
    ret <= 1'b0;
    do_reset(1'b0);
    check_state();
    @(posedge clock);
    ret <= 1'b1;
    set_mixed();
    do_reset(1'b1);
    check_state();
    // Interrupts from the third-port bit lines
    @(posedge clock);
    irq_clear <= 6'h3f;
    @(posedge clock);
    irq_clear <= 6'h00;
    tick(2);
    cmp(48'({irq_status, host_irq, int_out}), 48'h0);
    for (int j = 0; j < 4; j++) begin
      if (j == 3) begin
        // Group one high nibble is forced out, so bit 4 rises from the driven side
        wr_out(3, 8'h10);
      end else begin
        @(posedge clock);
        ext_en[(j/2)*24+(j%2)*4] <= 1'b1;
        tick(3);
        @(posedge clock);
        ext_val[(j/2)*24+(j%2)*4] <= 1'b1;
      end
      tick(3);
      cmp(48'(irq_status), 48'(6'h01 << j));
      cmp(48'({host_irq, int_out}), 48'h3);
      @(posedge clock);
      irq_clear[j] <= 1'b1;
      @(posedge clock);
      irq_clear[j] <= 1'b0;
      tick(2);
      cmp(48'({irq_status, host_irq, int_out}), 48'h0);
    end
    // Timer B stays idle on a still external clock, then cascades
    tick(100);
    cmp(48'(irq_status[5:4]), 48'h0);
    @(posedge clock);
    csel[1] <= 1'b1;
    wait_flag(4, 400);
    cmp(48'(int_out), 48'h1);
    // Event counter on its external clock: terminal on first edge, then after reload
    for (int p = 0; p < 5; p++) begin
      @(posedge clock);
      ext_clk[2] <= 1'b1;
      tick(2);
      @(posedge clock);
      ext_clk[2] <= 1'b0;
      tick(2);
      cmp(48'(irq_status[5]), 48'(p == 0 || p == 4));
      @(posedge clock);
      irq_clear[5] <= 1'b1;
      @(posedge clock);
      irq_clear[5] <= 1'b0;
    end
    tick(2);
    cmp(48'(n_evt), 48'h2);
    complete_run();
  end
endmodule
